// ==== core/timer_pkg.sv ====
// Shared constants and types for the timer event flag block.
package timer_pkg;
	localparam int CHANNELS = 2;
	localparam int FLAG_COUNT = CHANNELS + 1;
	// -------------------------------------------------------------------
	// Register byte offsets
	// -------------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_CLEAR = 8'h0c;
	localparam logic [7:0] ADDR_COUNT = 8'h10;
	localparam logic [7:0] ADDR_MODULUS = 8'h14;
	localparam logic [7:0] ADDR_CH_BASE = 8'h18;
	localparam logic [7:0] CH_STRIDE = 8'h08;
	localparam logic [7:0] CH_VALUE_OFS = 8'h04;
	// -------------------------------------------------------------------
	// Field positions
	// -------------------------------------------------------------------
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_CENTER_BIT = 1;
	localparam int CTRL_DIV_LSB = 2;
	localparam int DIV_WIDTH = 4;
	localparam int STATUS_OVF_BIT = 0;
	localparam int STATUS_CH_LSB = 1;
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_EDGE_LSB = 2;
	// -------------------------------------------------------------------
	// Reset values and count limits
	// -------------------------------------------------------------------
	localparam logic [5:0] CTRL_RESET = 6'h00;
	localparam logic [15:0] COUNT_ZERO = 16'h0000;
	localparam logic [15:0] COUNT_WRAP = 16'hffff;
	localparam logic [15:0] COUNT_STEP = 16'h0001;
	localparam logic [3:0] CFG_RESET = 4'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		MODE_CAPTURE = 2'h0,
		MODE_COMPARE = 2'h1,
		MODE_EDGE_PWM = 2'h2
	} channel_mode_type;
	typedef enum logic [1:0] {
		DIR_UP = 2'b01,
		DIR_DOWN = 2'b10
	} count_dir_type;
endpackage

// ==== core/chan_if.sv ====
// Link between the counter core and one channel's event logic.
`timescale 1ns/1ns
interface chan_if;
	logic tick;
	logic center;
	logic [15:0] next_count;
	logic [1:0] mode;
	logic [1:0] edge_sel;
	logic [15:0] value;
	logic capture_pin;
	logic hit;
	modport core(output tick, center, next_count, mode, edge_sel, value, capture_pin,
		input hit);
	modport chan(input tick, center, next_count, mode, edge_sel, value, capture_pin,
		output hit);
endinterface

// ==== core/timer_channel.sv ====
// Event detection for one timer channel: capture edges and count matches.
`timescale 1ns/1ns
module timer_channel (
	input wire logic clk_in,
	input wire logic reset_n_in,
	chan_if.chan port
);
	logic pin_last;
	logic rise;
	logic fall;
	logic match;

	// Previous pin sample; the pin is already synchronous to clk_in.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pin_last <= 1'b0;
		end else begin
			pin_last <= port.capture_pin;
		end
	end

	assign rise = port.capture_pin & ~pin_last;
	assign fall = ~port.capture_pin & pin_last;
	// Match against the count being entered, so the flag lands with the count.
	assign match = port.tick && (port.next_count == port.value);

	// Center mode turns every channel into a center-aligned PWM channel.
	always_comb begin
		port.hit = 1'b0;
		if (port.center) begin
			port.hit = match; // [RL7]
		end else begin
			unique case (port.mode)
				timer_pkg::MODE_CAPTURE: begin
					port.hit = (port.edge_sel[0] & rise) | (port.edge_sel[1] & fall); // [RL4]
				end
				timer_pkg::MODE_COMPARE: begin
					port.hit = match; // [RL5]
				end
				timer_pkg::MODE_EDGE_PWM: begin
					port.hit = match; // [RL6]
				end
				default: begin
					port.hit = 1'b0;
				end
			endcase
		end
	end

	AST_CAPTURE_RISE: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL4]
		!port.center && port.mode == timer_pkg::MODE_CAPTURE && port.edge_sel == 2'h1
		&& port.capture_pin && !$past(port.capture_pin) |-> port.hit)
		else $error("capture rise missed");
	AST_CAPTURE_OFF: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL4]
		!port.center && port.mode == timer_pkg::MODE_CAPTURE && port.edge_sel == 2'h0
		|-> !port.hit)
		else $error("capture fired while off");
	AST_CENTER_MATCH: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL7]
		port.center && port.tick && port.next_count == port.value |-> port.hit)
		else $error("center match missed");
	COV_CENTER_HIT: cover property (@(posedge clk_in) disable iff (!reset_n_in)
		port.center && port.hit);
endmodule

// ==== core/timer_event_flags.sv ====
// Timer counter with overflow and channel event flags behind AXI4-Lite.
// Summary of operation
// RL1 - Free up-count runs through 0xffff, wraps to 0x0000, sets overflow flag.
// RL2 - With a modulus set, overflow flag sets as count goes modulus to zero.
// RL3 - In up/down mode overflow flag sets when count turns down from modulus.
// RL4 - Capture edge select picks rising, falling, either or none; edge sets flag.
// RL5 - Output compare sets the channel flag whenever count equals channel value.
// RL6 - Edge-aligned PWM sets channel flag once per period at the match.
// RL7 - Center-aligned PWM sets channel flag at both up and down matches.
// RL8 - Flag clears by read while set then zero write; a new event keeps it.
// RL9 - Interrupt stays high while an enabled flag is set.
// RL10 - Center select one gives up/down counting, zero gives plain up-counting.
// RL11 - Flags set with their cause on the same edge, each independently.
`timescale 1ns/1ns
module timer_event_flags (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic [7:0] awaddr_in,
	input wire logic awvalid_in,
	output logic awready_out,
	input wire logic [31:0] wdata_in,
	input wire logic [3:0] wstrb_in,
	input wire logic wvalid_in,
	output logic wready_out,
	output logic [1:0] bresp_out,
	output logic bvalid_out,
	input wire logic bready_in,
	input wire logic [7:0] araddr_in,
	input wire logic arvalid_in,
	output logic arready_out,
	output logic [31:0] rdata_out,
	output logic [1:0] rresp_out,
	output logic rvalid_out,
	input wire logic rready_in,
	input wire logic [timer_pkg::CHANNELS-1:0] capture_in,
	output logic irq_out
);
	localparam int NCH = timer_pkg::CHANNELS;
	localparam int NF = timer_pkg::FLAG_COUNT;

	logic [7:0] waddr;
	logic [31:0] wdata;
	logic [3:0] wstrb;
	logic [31:0] wmask;
	logic do_write;
	logic [31:0] read_word;
	logic read_err;
	logic write_err;
	logic [5:0] ctrl;
	logic [NF-1:0] irq_en;
	logic [NF-1:0] flags;
	logic [NF-1:0] armed;
	logic [NF-1:0] events;
	logic [NF-1:0] clear_req;
	logic [NF-1:0] next_flags;
	logic [NF-1:0] next_armed;
	logic [15:0] modulus;
	logic [15:0] count;
	logic [15:0] next_count;
	logic [3:0] ch_cfg [NCH];
	logic [15:0] ch_value [NCH];
	logic [NCH-1:0] ch_hit;
	logic [timer_pkg::DIV_WIDTH-1:0] div_cnt;
	logic run;
	logic center;
	logic tick;
	logic ovf_ev;
	logic status_read;
	timer_pkg::count_dir_type dir;
	timer_pkg::count_dir_type next_dir;

	assign run = ctrl[timer_pkg::CTRL_RUN_BIT];
	assign center = ctrl[timer_pkg::CTRL_CENTER_BIT];

	// -------------------------------------------------------------------
	// AXI4-Lite slave
	// -------------------------------------------------------------------

	// Address and data are taken in either order; the write happens once both are held.
	assign do_write = !awready_out && !wready_out && !bvalid_out;
	assign wmask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};

	// Write channel handshakes and response.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			awready_out <= 1'b1;
			wready_out <= 1'b1;
			bvalid_out <= 1'b0;
			bresp_out <= timer_pkg::RESP_OKAY;
			waddr <= 8'h00;
			wdata <= 32'h0000_0000;
			wstrb <= 4'h0;
		end else begin
			if (awvalid_in && awready_out) begin
				awready_out <= 1'b0;
				waddr <= awaddr_in;
			end
			if (wvalid_in && wready_out) begin
				wready_out <= 1'b0;
				wdata <= wdata_in;
				wstrb <= wstrb_in;
			end
			if (do_write) begin
				bvalid_out <= 1'b1;
				bresp_out <= write_err ? timer_pkg::RESP_SLVERR : timer_pkg::RESP_OKAY;
			end
			if (bvalid_out && bready_in) begin
				bvalid_out <= 1'b0;
				awready_out <= 1'b1;
				wready_out <= 1'b1;
			end
		end
	end

	// Read data selection; unmapped or misaligned addresses answer SLVERR.
	always_comb begin
		read_word = 32'h0000_0000;
		read_err = 1'b0;
		unique case (araddr_in)
			timer_pkg::ADDR_CTRL: read_word = {26'h0, ctrl};
			timer_pkg::ADDR_IRQ_EN: read_word = {29'h0, irq_en};
			timer_pkg::ADDR_STATUS: read_word = {29'h0, flags};
			timer_pkg::ADDR_CLEAR: read_word = 32'h0000_0000;
			timer_pkg::ADDR_COUNT: read_word = {16'h0, count};
			timer_pkg::ADDR_MODULUS: read_word = {16'h0, modulus};
			default: read_err = 1'b1;
		endcase
		for (int i = 0; i < NCH; i++) begin
			if (araddr_in == 8'(timer_pkg::ADDR_CH_BASE + i * timer_pkg::CH_STRIDE)) begin
				read_word = {28'h0, ch_cfg[i]};
				read_err = 1'b0;
			end
			if (araddr_in == 8'(timer_pkg::ADDR_CH_BASE + i * timer_pkg::CH_STRIDE
				+ timer_pkg::CH_VALUE_OFS)) begin
				read_word = {16'h0, ch_value[i]};
				read_err = 1'b0;
			end
		end
	end

	// Same decode for the held write address.
	always_comb begin
		write_err = 1'b1;
		unique case (waddr)
			timer_pkg::ADDR_CTRL, timer_pkg::ADDR_IRQ_EN, timer_pkg::ADDR_STATUS,
			timer_pkg::ADDR_CLEAR, timer_pkg::ADDR_COUNT,
			timer_pkg::ADDR_MODULUS: write_err = 1'b0;
			default: write_err = 1'b1;
		endcase
		for (int i = 0; i < NCH; i++) begin
			if (waddr[7:3] == 5'(8'(timer_pkg::ADDR_CH_BASE + i * timer_pkg::CH_STRIDE) >> 3)
				&& waddr[1:0] == 2'h0) begin
				write_err = 1'b0;
			end
		end
	end

	// Read channel; the answer comes one cycle after the address is taken.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			arready_out <= 1'b1;
			rvalid_out <= 1'b0;
			rdata_out <= 32'h0000_0000;
			rresp_out <= timer_pkg::RESP_OKAY;
		end else begin
			if (arvalid_in && arready_out) begin
				arready_out <= 1'b0;
				rvalid_out <= 1'b1;
				rdata_out <= read_word;
				rresp_out <= read_err ? timer_pkg::RESP_SLVERR : timer_pkg::RESP_OKAY;
			end else if (rvalid_out && rready_in) begin
				rvalid_out <= 1'b0;
				arready_out <= 1'b1;
			end
		end
	end

	// -------------------------------------------------------------------
	// Software registers
	// -------------------------------------------------------------------

	// Capture hardware overrides a software write landing in the same cycle.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ctrl <= timer_pkg::CTRL_RESET;
			irq_en <= '0;
			modulus <= timer_pkg::COUNT_ZERO;
			for (int i = 0; i < NCH; i++) begin
				ch_cfg[i] <= timer_pkg::CFG_RESET;
				ch_value[i] <= timer_pkg::COUNT_ZERO;
			end
		end else begin
			if (do_write && waddr == timer_pkg::ADDR_CTRL) begin
				ctrl <= (ctrl & ~wmask[5:0]) | (wdata[5:0] & wmask[5:0]);
			end
			if (do_write && waddr == timer_pkg::ADDR_IRQ_EN) begin
				irq_en <= (irq_en & ~wmask[NF-1:0]) | (wdata[NF-1:0] & wmask[NF-1:0]);
			end
			if (do_write && waddr == timer_pkg::ADDR_MODULUS) begin
				modulus <= (modulus & ~wmask[15:0]) | (wdata[15:0] & wmask[15:0]);
			end
			for (int i = 0; i < NCH; i++) begin
				if (do_write && waddr == 8'(timer_pkg::ADDR_CH_BASE + i * timer_pkg::CH_STRIDE)) begin
					ch_cfg[i] <= (ch_cfg[i] & ~wmask[3:0]) | (wdata[3:0] & wmask[3:0]);
				end
				if (do_write && waddr == 8'(timer_pkg::ADDR_CH_BASE + i * timer_pkg::CH_STRIDE
					+ timer_pkg::CH_VALUE_OFS)) begin
					ch_value[i] <= (ch_value[i] & ~wmask[15:0]) | (wdata[15:0] & wmask[15:0]);
				end
				if (ch_hit[i] && !center && ch_cfg[i][1:0] == timer_pkg::MODE_CAPTURE) begin
					ch_value[i] <= count;
				end
			end
		end
	end

	// -------------------------------------------------------------------
	// Counting clock and counter
	// -------------------------------------------------------------------

	// One counting tick every divide+1 system clocks while running.
	assign tick = run && (div_cnt == ctrl[timer_pkg::CTRL_DIV_LSB +: timer_pkg::DIV_WIDTH]);

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			div_cnt <= '0;
		end else if (!run || tick) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= div_cnt + 4'h1;
		end
	end

	// Modulus zero means free running; in up/down mode it has no turning point.
	always_comb begin
		next_count = count;
		next_dir = dir;
		ovf_ev = 1'b0;
		if (tick && !center) begin
			next_dir = timer_pkg::DIR_UP; // [RL10]
			if ((modulus != timer_pkg::COUNT_ZERO && count == modulus)
				|| count == timer_pkg::COUNT_WRAP) begin
				next_count = timer_pkg::COUNT_ZERO; // [RL1] [RL2]
				ovf_ev = 1'b1;
			end else begin
				next_count = count + timer_pkg::COUNT_STEP;
			end
		end else if (tick) begin
			unique case (dir)
				timer_pkg::DIR_UP: begin
					if (modulus != timer_pkg::COUNT_ZERO && count >= modulus) begin
						next_dir = timer_pkg::DIR_DOWN; // [RL3] [RL10]
						next_count = count - timer_pkg::COUNT_STEP;
						ovf_ev = 1'b1;
					end else begin
						next_count = count + timer_pkg::COUNT_STEP;
					end
				end
				timer_pkg::DIR_DOWN: begin
					if (count == timer_pkg::COUNT_ZERO) begin
						next_dir = timer_pkg::DIR_UP;
						next_count = count + timer_pkg::COUNT_STEP;
					end else begin
						next_count = count - timer_pkg::COUNT_STEP;
					end
				end
				default: begin
					next_dir = timer_pkg::DIR_UP;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			count <= timer_pkg::COUNT_ZERO;
			dir <= timer_pkg::DIR_UP;
		end else begin
			count <= next_count;
			dir <= next_dir;
		end
	end

	// -------------------------------------------------------------------
	// Channels
	// -------------------------------------------------------------------

	for (genvar g = 0; g < NCH; g++) begin : gen_chan
		chan_if bus();
		assign bus.tick = tick;
		assign bus.center = center;
		assign bus.next_count = next_count;
		assign bus.mode = ch_cfg[g][timer_pkg::CFG_MODE_LSB +: 2];
		assign bus.edge_sel = ch_cfg[g][timer_pkg::CFG_EDGE_LSB +: 2];
		assign bus.value = ch_value[g];
		assign bus.capture_pin = capture_in[g];
		assign ch_hit[g] = bus.hit;
		timer_channel u_chan (
			.clk_in(clk_in),
			.reset_n_in(reset_n_in),
			.port(bus.chan)
		);
	end

	// -------------------------------------------------------------------
	// Event flags and interrupt
	// -------------------------------------------------------------------

	assign events = {ch_hit, ovf_ev}; // [RL11]
	assign status_read = arvalid_in && arready_out && araddr_in == timer_pkg::ADDR_STATUS;

	// A zero to STATUS, or a one to CLEAR, completes the clear on an armed flag.
	always_comb begin
		clear_req = '0;
		if (do_write && wstrb[0] && waddr == timer_pkg::ADDR_STATUS) begin
			clear_req = ~wdata[NF-1:0];
		end else if (do_write && wstrb[0] && waddr == timer_pkg::ADDR_CLEAR) begin
			clear_req = wdata[NF-1:0];
		end
	end

	// An event disarms its flag, so a clear racing a new event never loses it.
	always_comb begin
		next_armed = status_read ? flags : armed;
		next_armed = next_armed & ~clear_req & ~events; // [RL8]
		next_flags = (flags & ~(armed & clear_req)) | events; // [RL8] [RL11]
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			flags <= '0;
			armed <= '0;
			irq_out <= 1'b0;
		end else begin
			flags <= next_flags;
			armed <= next_armed;
			irq_out <= |(flags & irq_en); // [RL9]
		end
	end

	AST_FREE_WRAP: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL1]
		tick && !center && count == timer_pkg::COUNT_WRAP
		|=> count == timer_pkg::COUNT_ZERO && flags[timer_pkg::STATUS_OVF_BIT])
		else $error("free wrap did not set overflow");
	AST_MOD_WRAP: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL2]
		tick && !center && modulus != timer_pkg::COUNT_ZERO && count == modulus
		|=> count == timer_pkg::COUNT_ZERO && flags[timer_pkg::STATUS_OVF_BIT])
		else $error("modulus wrap did not set overflow");
	AST_CENTER_TURN: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL3]
		tick && center && dir == timer_pkg::DIR_UP && modulus != timer_pkg::COUNT_ZERO
		&& count == modulus |=> count == $past(count) - timer_pkg::COUNT_STEP
		&& dir == timer_pkg::DIR_DOWN && flags[timer_pkg::STATUS_OVF_BIT])
		else $error("center turn wrong");
	AST_CENTER_NO_OVF: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL10]
		center && dir == timer_pkg::DIR_DOWN |-> !ovf_ev)
		else $error("overflow while counting down");
	AST_COMPARE_FLAG: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL5]
		tick && !center && ch_cfg[0][1:0] == timer_pkg::MODE_COMPARE
		&& next_count == ch_value[0] |=> flags[timer_pkg::STATUS_CH_LSB])
		else $error("compare flag missed");
	AST_CLEAR_NEEDS_READ: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL8]
		flags[0] && !armed[0] |=> flags[0])
		else $error("flag cleared without read");
	AST_EVENT_WINS: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL8]
		ovf_ev ##1 (do_write && clear_req[0]) |=> flags[0])
		else $error("event lost to clear");
	AST_IRQ_LEVEL: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL9]
		((flags & irq_en) != '0) |=> irq_out)
		else $error("irq not raised");
	AST_IRQ_QUIET: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [RL9]
		((flags & irq_en) == '0) |=> !irq_out)
		else $error("irq without enabled flag");
	COV_CENTER_OVF: cover property (@(posedge clk_in) disable iff (!reset_n_in)
		center && ovf_ev);
	COV_TWO_STEP_CLEAR: cover property (@(posedge clk_in) disable iff (!reset_n_in)
		status_read && flags[0] ##[1:20] (flags[0] && !next_flags[0]));
	COV_CAPTURE: cover property (@(posedge clk_in) disable iff (!reset_n_in)
		!center && ch_hit[0] && ch_cfg[0][1:0] == timer_pkg::MODE_CAPTURE);
endmodule

// ==== dv/tb.sv ====
// Self-checking testbench for the timer event flag block.
`timescale 1ns/1ns
`define CHECK(got, exp) begin \
	compares++; \
	if ((got) !== (exp)) begin \
		fails++; \
		$display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); \
	end \
end
module tb;
	// ---------------------------------------------------------------
	// Stimulus signals and bookkeeping
	// ---------------------------------------------------------------
	typedef struct {
		logic [31:0] mask;
		logic [1:0] resp;
		logic [31:0] data;
	} exp_type;
	localparam int LIMIT = 90000;
	logic clk_in = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [1:0] capture = 2'h0;
	logic awready_out;
	logic wready_out;
	logic [1:0] bresp_out;
	logic bvalid_out;
	logic arready_out;
	logic [31:0] rdata_out;
	logic [1:0] rresp_out;
	logic rvalid_out;
	logic irq_out;
	logic [15:0] seed = 16'h46f2;
	int fails = 0;
	int compares = 0;
	int cyc = 0;
	exp_type exp_q[$];

	timer_event_flags i_dut (
		.clk_in(clk_in), .reset_n_in(reset_n),
		.awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready_out),
		.wdata_in(wdata), .wstrb_in(4'hf), .wvalid_in(wvalid), .wready_out(wready_out),
		.bresp_out(bresp_out), .bvalid_out(bvalid_out), .bready_in(bready),
		.araddr_in(araddr), .arvalid_in(arvalid), .arready_out(arready_out),
		.rdata_out(rdata_out), .rresp_out(rresp_out), .rvalid_out(rvalid_out),
		.rready_in(rready), .capture_in(capture), .irq_out(irq_out)
	);

	// The clock toggles every half period of 2 ns.
	always #2 clk_in = ~clk_in;

	// Cycle counter; a hung wait ends the run here as a mismatch.
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			fails++;
			final_report();
		end
	end

	// Every read answer is matched against the oldest expectation noted.
	always @(posedge clk_in) begin
		exp_type e;
		if (rvalid_out === 1'b1 && rready === 1'b1) begin
			e = exp_q.pop_front();
			`CHECK({rresp_out, rdata_out & e.mask}, {e.resp, e.data})
		end
	end

	// ---------------------------------------------------------------
	// Bus and timing helpers
	// ---------------------------------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic final_report();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Both channels are offered together and released as each is taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk_in);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_in);
			if (awready_out === 1'b1)
				awvalid <= 1'b0;
			if (wready_out === 1'b1)
				wvalid <= 1'b0;
		end while (bvalid_out !== 1'b1);
		bready <= 1'b0;
		`CHECK(bresp_out, er)
	endtask

	// The expectation is noted before the request so the monitor finds it.
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] d,
			input logic [1:0] er);
		exp_q.push_back('{m, er, d});
		@(posedge clk_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_in);
			if (arready_out === 1'b1)
				arvalid <= 1'b0;
		end while (rvalid_out !== 1'b1);
		rready <= 1'b0;
	endtask

	// Arming read of the flags, then a clear of the chosen bits. An event that lands
	// between the read and the write keeps its flag set, so the pair is repeated until
	// the request drops; otherwise the next rise would never be seen.
	task automatic clr(input logic [31:0] bits);
		do begin
			rd(timer_pkg::ADDR_STATUS, 32'h0, 32'h0, timer_pkg::RESP_OKAY);
			wr(timer_pkg::ADDR_CLEAR, bits, timer_pkg::RESP_OKAY);
			@(posedge clk_in);
		end while (irq_out === 1'b1);
	endtask

	// Cycle at which the interrupt is next seen rising.
	task automatic wait_rise(output int t);
		while (irq_out !== 1'b0)
			@(posedge clk_in);
		while (irq_out !== 1'b1)
			@(posedge clk_in);
		t = cyc;
	endtask

	// Spacing of two successive events of one flag, in clock cycles.
	task automatic period(input logic [31:0] bits, input int gap);
		int t0;
		int t1;
		clr(bits);
		wait_rise(t0);
		clr(bits);
		wait_rise(t1);
		`CHECK(t1 - t0, gap)
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		int ts;
		int t;
		int t2;
		logic [7:0] cfg;
		logic exp_bit;
		repeat (3) @(posedge clk_in);
		reset_n <= 1'b1;
		// Every mapped register starts at zero; an unmapped place is refused.
		for (int a = 0; a <= 'h24; a += 4)
			rd(a[7:0], 32'hffffffff, 32'h0, timer_pkg::RESP_OKAY);
		rd(8'h80, 32'hffffffff, 32'h0, timer_pkg::RESP_SLVERR);
		wr(8'h80, 32'h1, timer_pkg::RESP_SLVERR);
		seed = lfsr(seed);
		wr(timer_pkg::ADDR_MODULUS, {16'h0, seed}, timer_pkg::RESP_OKAY);
		rd(timer_pkg::ADDR_MODULUS, 32'hffffffff, {16'h0, seed}, timer_pkg::RESP_OKAY);
		wr(timer_pkg::ADDR_MODULUS, 32'h0, timer_pkg::RESP_OKAY);
		// Free run: one overflow after the full 16-bit range.
		wr(timer_pkg::ADDR_IRQ_EN, 32'h1, timer_pkg::RESP_OKAY);
		wr(timer_pkg::ADDR_CTRL, 32'h1, timer_pkg::RESP_OKAY);
		ts = cyc;
		wait_rise(t);
		// The modulus is set right after the wrap, while the count is still low.
		wr(timer_pkg::ADDR_MODULUS, 32'h2000, timer_pkg::RESP_OKAY);
		`CHECK((t - ts) inside {[65530:65540]}, 1'b1)
		wr(timer_pkg::ADDR_STATUS, 32'h0, timer_pkg::RESP_OKAY);
		rd(timer_pkg::ADDR_STATUS, 32'h7, 32'h1, timer_pkg::RESP_OKAY);
		// Masking the overflow source drops the request; unmasking restores it.
		wr(timer_pkg::ADDR_IRQ_EN, 32'h0, timer_pkg::RESP_OKAY);
		repeat (2) @(posedge clk_in);
		`CHECK(irq_out, 1'b0)
		wr(timer_pkg::ADDR_IRQ_EN, 32'h1, timer_pkg::RESP_OKAY);
		repeat (2) @(posedge clk_in);
		`CHECK(irq_out, 1'b1)
		wr(timer_pkg::ADDR_STATUS, 32'h0, timer_pkg::RESP_OKAY);
		rd(timer_pkg::ADDR_STATUS, 32'h1, 32'h0, timer_pkg::RESP_OKAY);
		wait_rise(t2);
		wr(timer_pkg::ADDR_MODULUS, 32'h9, timer_pkg::RESP_OKAY);
		wr(timer_pkg::ADDR_CTRL, 32'h5, timer_pkg::RESP_OKAY);
		`CHECK(t2 - t, 8193)
		// An overflow between the arming read and the write keeps the flag.
		rd(timer_pkg::ADDR_STATUS, 32'h0, 32'h0, timer_pkg::RESP_OKAY);
		repeat (25) @(posedge clk_in);
		wr(timer_pkg::ADDR_STATUS, 32'h0, timer_pkg::RESP_OKAY);
		rd(timer_pkg::ADDR_STATUS, 32'h1, 32'h1, timer_pkg::RESP_OKAY);
		period(32'h1, 20);
		// Compare and edge PWM on channel 0: one event per 10-count period.
		seed = lfsr(seed);
		wr(timer_pkg::ADDR_CH_BASE + 8'h04, {28'h0, 4'(seed % 10)}, timer_pkg::RESP_OKAY);
		wr(timer_pkg::ADDR_CH_BASE, 32'h1, timer_pkg::RESP_OKAY);
		wr(timer_pkg::ADDR_IRQ_EN, 32'h2, timer_pkg::RESP_OKAY);
		period(32'h2, 20);
		wr(timer_pkg::ADDR_CH_BASE, 32'h2, timer_pkg::RESP_OKAY);
		period(32'h2, 20);
		// Up/down counting with modulus 6 and a tick every 16 clocks.
		wr(timer_pkg::ADDR_IRQ_EN, 32'h1, timer_pkg::RESP_OKAY);
		clr(32'h1);
		wait_rise(t);
		wr(timer_pkg::ADDR_CTRL, 32'h3f, timer_pkg::RESP_OKAY);
		wr(timer_pkg::ADDR_MODULUS, 32'h6, timer_pkg::RESP_OKAY);
		period(32'h1, 192);
		wr(timer_pkg::ADDR_CH_BASE + 8'h04, 32'h3, timer_pkg::RESP_OKAY);
		wr(timer_pkg::ADDR_IRQ_EN, 32'h2, timer_pkg::RESP_OKAY);
		period(32'h2, 96);
		// Capture edge selection on both channels, every code and edge.
		wr(timer_pkg::ADDR_CTRL, 32'h1, timer_pkg::RESP_OKAY);
		wr(timer_pkg::ADDR_IRQ_EN, 32'h0, timer_pkg::RESP_OKAY);
		for (int ch = 0; ch < 2; ch++) begin
			cfg = timer_pkg::ADDR_CH_BASE + 8'(ch * 8);
			for (int sel = 0; sel < 4; sel++) begin
				wr(cfg, 32'(sel << 2), timer_pkg::RESP_OKAY);
				for (int e = 0; e < 2; e++) begin
					clr(32'h2 << ch);
					capture[ch] <= (e == 0);
					repeat (3) @(posedge clk_in);
					exp_bit = (e == 0) ? sel[0] : sel[1];
					rd(timer_pkg::ADDR_STATUS, 32'h2 << ch, 32'(exp_bit) << (ch + 1),
						timer_pkg::RESP_OKAY);
				end
			end
		end
		final_report();
	end
endmodule
